// ===== inc/bfs_pkg.sv
// Shared constants and types for the regulator fault/status register bank
package bfs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W     = 3;
    localparam logic [2:0]  ADDR_STAT  = 3'h0;
    localparam logic [2:0]  ADDR_CFG1  = 3'h1;
    localparam logic [2:0]  ADDR_CFG2  = 3'h2;
    localparam logic [2:0]  ADDR_LEVEL = 3'h3;
    localparam logic [2:0]  ADDR_CMD   = 3'h4;

    // Status bit positions
    localparam int unsigned ST_OCF  = 7;
    localparam int unsigned ST_TSD  = 6;
    localparam int unsigned ST_TWRN = 5;
    localparam int unsigned ST_ZERO = 4;
    localparam int unsigned ST_EN   = 3;
    localparam int unsigned ST_ONE  = 2;
    localparam int unsigned ST_OK   = 1;
    localparam int unsigned ST_PG   = 0;

    // Writable field masks; unimplemented bits read zero
    localparam logic [7:0] CFG1_MASK = 8'hF8;
    localparam logic [7:0] CFG2_MASK = 8'h7F;
    localparam logic [7:0] CMD_MASK  = 8'hFE;
    localparam logic [7:0] MRG_MASK  = 8'h0C;
    localparam int unsigned CMD_CLR  = 0;

    // Synchronised pin indices
    localparam int unsigned NSYNC  = 6;
    localparam int unsigned SY_EN  = 0;
    localparam int unsigned SY_PG  = 1;
    localparam int unsigned SY_TW  = 2;
    localparam int unsigned SY_TSD = 3;
    localparam int unsigned SY_LS  = 4;
    localparam int unsigned SY_HS  = 5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_NS    = 10;
    localparam int unsigned BLANK_NS  = 108;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  BLANK_LD  = 4'(BLANK_CYC);
    localparam logic [3:0]  HICC_MAX  = 4'hF;
    localparam logic [3:0]  HICC_MIN  = 4'h0;
    localparam int unsigned TMR_W     = 24;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b01,
        ST_INHIBIT = 2'b10
    } bfs_state_e;

    // Register access strobes from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bfs_reg_req_s;

    // Configuration fields handed to the analog control
    typedef struct packed {
        logic [1:0] current_limit_sel;
        logic [2:0] freq_sel;
        logic [2:0] startup_delay_sel;
        logic [1:0] margin_sel;
        logic [1:0] soft_start_sel;
        logic [7:0] output_level_value;
    } bfs_cfg_s;

endpackage

// ===== rtl/bfs_regs.sv
// Fault, hiccup and register logic of the step-down regulator
// Operation
// - Thermal shutdown stops power stage only, not interface
// - Thermal warning is register bit only, polled
// - Low-side over limit blocks high-side turn-on
// - Two-bit field selects four low-side limits
// - High-side limit ends on-time immediately
// - 108 ns blanking masks high-side limit
// - Four-bit counter increments on low-side limit cycle
// - Decrements otherwise, saturates at 0000 and 1111
// - High-side limits never touch the counter
// - At 1111 tri-state switches for timed inhibit
// - After inhibit, restart with fresh soft-start
// - Hiccup stays armed during soft-start too
// - Five byte registers at addresses 0 to 4
// - Flags latch until command clear or power cycle
// - Status bits 3 and 0 follow their pins live
// - Status resets zero except bits 2 and 1
// - Bit 7 latches any overcurrent
// - Bits 6,5 latch thermal; bit 4 zero
// - Bit 3 shows enable pin live
// - Bit 0 shows power good pin live
// - Config resets to factory values on power-up, margin field to 00
// - Clear bit clears flags then self-clears
// - Supply lockout resets registers; enable does not
`timescale 1ns/1ns
`default_nettype none
module bfs_regs
    import bfs_pkg::*;
#(
    parameter int unsigned INH_NS0  = 84_375_000,
    parameter int unsigned INH_NS1  = 35_526_315,
    parameter int unsigned INH_NS2  = 17_763_157,
    parameter int unsigned INH_NS3  = 9_000_000,
    parameter logic [7:0]  CFG1_RST = 8'h00,
    parameter logic [7:0]  CFG2_RST = 8'h00,
    parameter logic [7:0]  LVL_RST  = 8'h00
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire bfs_reg_req_s reg_req_i,
    output logic [7:0]        reg_rdata_o,
    input  wire logic         en_pin_i,
    input  wire logic         pg_pin_i,
    input  wire logic         therm_warn_i,
    input  wire logic         therm_sd_i,
    input  wire logic         ls_limit_i,
    input  wire logic         hs_limit_i,
    input  wire logic         sw_cycle_i,
    input  wire logic         hs_req_i,
    input  wire logic         ls_req_i,
    output logic              hs_gate_o,
    output logic              ls_gate_o,
    output logic              stage_off_o,
    output logic              ss_restart_o,
    output logic              ldo_enable_o,
    output bfs_cfg_s          cfg_o
);

    // Inhibit lengths in cycles; every time rounds down
    localparam logic [TMR_W-1:0] INH_C0 = TMR_W'(INH_NS0 / CLK_NS);
    localparam logic [TMR_W-1:0] INH_C1 = TMR_W'(INH_NS1 / CLK_NS);
    localparam logic [TMR_W-1:0] INH_C2 = TMR_W'(INH_NS2 / CLK_NS);
    localparam logic [TMR_W-1:0] INH_C3 = TMR_W'(INH_NS3 / CLK_NS);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign pin_raw = {hs_limit_i, ls_limit_i, therm_sd_i,
                      therm_warn_i, pg_pin_i, en_pin_i};

    // Comparators and pins are asynchronous to clk_i
    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                sync1_reg[g] <= 1'b0;
                sync2_reg[g] <= 1'b0;
            end else begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    logic en_s, pg_s, tw_s, tsd_s, ls_s, hs_s;
    assign en_s  = sync2_reg[SY_EN];
    assign pg_s  = sync2_reg[SY_PG];
    assign tw_s  = sync2_reg[SY_TW];
    assign tsd_s = sync2_reg[SY_TSD];
    assign ls_s  = sync2_reg[SY_LS];
    assign hs_s  = sync2_reg[SY_HS];

    // ------------------------------------------------------------------
    // Registers and protection state
    // ------------------------------------------------------------------
    logic [7:0]       cfg1_reg, cfg1_next;
    logic [7:0]       cfg2_reg, cfg2_next;
    logic [7:0]       lvl_reg, lvl_next;
    logic [7:0]       cmd_reg, cmd_next;
    logic             clr_reg, clr_next;
    logic             ocf_reg, ocf_next;
    logic             tsdf_reg, tsdf_next;
    logic             twf_reg, twf_next;
    logic [7:0]       rdata_reg, rdata_next;
    logic [7:0]       status;
    logic [3:0]       hicc_reg, hicc_next;
    logic             ls_seen_reg, ls_seen_next;
    bfs_state_e       state_reg, state_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic             retry_reg, retry_next;
    logic             hs_prev_reg, hs_prev_next;
    logic [3:0]       blank_reg, blank_next;
    logic             trunc_reg, trunc_next;
    logic             hs_gate_reg, hs_gate_next;
    logic             ls_gate_reg, ls_gate_next;
    logic             run;
    logic             trunc_now;
    logic             hs_rise;
    logic             cyc_evt;
    logic [TMR_W-1:0] inh_load;
    logic             wr_hit;

    // Status image; bit 1 reads one while no flag is up
    always_comb begin
        status          = 8'h00;
        status[ST_OCF]  = ocf_reg;
        status[ST_TSD]  = tsdf_reg;
        status[ST_TWRN] = twf_reg;
        status[ST_ZERO] = 1'b0;
        status[ST_EN]   = en_s;
        status[ST_ONE]  = 1'b1;
        status[ST_OK]   = ~(ocf_reg | tsdf_reg | twf_reg);
        status[ST_PG]   = pg_s;
    end

    // Inhibit terminal count from the soft-start select
    always_comb begin
        case (cfg2_reg[1:0])
            2'd0:    inh_load = INH_C0;
            2'd1:    inh_load = INH_C1;
            2'd2:    inh_load = INH_C2;
            default: inh_load = INH_C3;
        endcase
    end

    // Next-state logic for registers, flags and protection
    always_comb begin
        wr_hit    = reg_req_i.wr;
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        lvl_next  = lvl_reg;
        cmd_next  = cmd_reg;
        clr_next  = 1'b0;
        if (wr_hit) begin
            case (reg_req_i.addr)
                ADDR_CFG1:  cfg1_next = reg_req_i.wdata & CFG1_MASK;
                ADDR_CFG2:  cfg2_next = reg_req_i.wdata & CFG2_MASK;
                ADDR_LEVEL: lvl_next  = reg_req_i.wdata;
                ADDR_CMD: begin
                    cmd_next = reg_req_i.wdata & CMD_MASK;
                    clr_next = reg_req_i.wdata[CMD_CLR];
                end
                default:    cmd_next = cmd_reg;
            endcase
        end
        // Set beats clear so an event in the clear cycle survives
        ocf_next  = (ocf_reg & ~clr_reg) | ls_s | hs_s;
        tsdf_next = (tsdf_reg & ~clr_reg) | tsd_s;
        twf_next  = (twf_reg & ~clr_reg) | tw_s;
        rdata_next = rdata_reg;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                ADDR_STAT:  rdata_next = status;
                ADDR_CFG1:  rdata_next = cfg1_reg;
                ADDR_CFG2:  rdata_next = cfg2_reg;
                ADDR_LEVEL: rdata_next = lvl_reg;
                ADDR_CMD:   rdata_next = cmd_reg | {7'h00, clr_reg};
                default:    rdata_next = 8'h00;
            endcase
        end

        // Hiccup integrator, one step per switching cycle
        cyc_evt      = ls_seen_reg | ls_s;
        ls_seen_next = sw_cycle_i ? 1'b0 : cyc_evt;
        hicc_next    = hicc_reg;
        state_next   = state_reg;
        tmr_next     = tmr_reg;
        retry_next   = 1'b0;
        case (state_reg)
            ST_RUN: begin
                // Armed in every phase, soft-start included
                if (hicc_reg == HICC_MAX) begin
                    state_next = ST_INHIBIT;
                    tmr_next   = inh_load;
                end else if (sw_cycle_i) begin
                    if (cyc_evt) begin
                        hicc_next = hicc_reg + 4'h1;
                    end else if (hicc_reg != HICC_MIN) begin
                        hicc_next = hicc_reg - 4'h1;
                    end
                end
            end
            ST_INHIBIT: begin
                if (tmr_reg == '0) begin
                    state_next = ST_RUN;
                    retry_next = 1'b1;
                    hicc_next  = HICC_MIN;
                end else begin
                    tmr_next = tmr_reg - TMR_W'(1);
                end
            end
            default: begin
                state_next = ST_RUN;
                hicc_next  = HICC_MIN;
            end
        endcase

        // Blanking restarts at every high-side turn-on request
        hs_prev_next = hs_req_i;
        hs_rise      = hs_req_i & ~hs_prev_reg;
        blank_next   = blank_reg;
        if (hs_rise) begin
            blank_next = BLANK_LD;
        end else if (blank_reg != 4'h0) begin
            blank_next = blank_reg - 4'h1;
        end
        // The turn-on cycle itself is blanked, before the timer loads
        trunc_now  = trunc_reg
                   | (hs_s & (blank_reg == 4'h0) & ~hs_rise);
        trunc_next = hs_req_i & trunc_now;

        // Thermal shutdown and hiccup drop the stage only
        run = (state_reg == ST_RUN) & ~tsd_s & en_s;
        hs_gate_next = run & hs_req_i & ~ls_s & ~trunc_now;
        ls_gate_next = run & ls_req_i & ~hs_gate_next;
    end

    // Supply-lockout reset restores factory values, margin field to 00
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg1_reg    <= CFG1_RST & CFG1_MASK;
            cfg2_reg    <= CFG2_RST & CFG2_MASK & ~MRG_MASK;
            lvl_reg     <= LVL_RST;
            cmd_reg     <= 8'h00;
            clr_reg     <= 1'b0;
            ocf_reg     <= 1'b0;
            tsdf_reg    <= 1'b0;
            twf_reg     <= 1'b0;
            rdata_reg   <= 8'h00;
            hicc_reg    <= HICC_MIN;
            ls_seen_reg <= 1'b0;
            state_reg   <= ST_RUN;
            tmr_reg     <= '0;
            retry_reg   <= 1'b0;
            hs_prev_reg <= 1'b0;
            blank_reg   <= 4'h0;
            trunc_reg   <= 1'b0;
            hs_gate_reg <= 1'b0;
            ls_gate_reg <= 1'b0;
        end else begin
            cfg1_reg    <= cfg1_next;
            cfg2_reg    <= cfg2_next;
            lvl_reg     <= lvl_next;
            cmd_reg     <= cmd_next;
            clr_reg     <= clr_next;
            ocf_reg     <= ocf_next;
            tsdf_reg    <= tsdf_next;
            twf_reg     <= twf_next;
            rdata_reg   <= rdata_next;
            hicc_reg    <= hicc_next;
            ls_seen_reg <= ls_seen_next;
            state_reg   <= state_next;
            tmr_reg     <= tmr_next;
            retry_reg   <= retry_next;
            hs_prev_reg <= hs_prev_next;
            blank_reg   <= blank_next;
            trunc_reg   <= trunc_next;
            hs_gate_reg <= hs_gate_next;
            ls_gate_reg <= ls_gate_next;
        end
    end

    // Outputs
    assign reg_rdata_o  = rdata_reg;
    assign hs_gate_o    = hs_gate_reg;
    assign ls_gate_o    = ls_gate_reg;
    assign stage_off_o  = (state_reg != ST_RUN);
    assign ss_restart_o = retry_reg;
    assign ldo_enable_o = 1'b1;
    assign cfg_o.current_limit_sel  = cfg1_reg[7:6];
    assign cfg_o.freq_sel           = cfg1_reg[5:3];
    assign cfg_o.startup_delay_sel  = cfg2_reg[6:4];
    assign cfg_o.margin_sel         = cfg2_reg[3:2];
    assign cfg_o.soft_start_sel     = cfg2_reg[1:0];
    assign cfg_o.output_level_value = lvl_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_full;
        state_reg == ST_RUN && hicc_reg == HICC_MAX;
    endsequence
    sequence s_expire;
        state_reg == ST_INHIBIT && tmr_reg == '0;
    endsequence

    hicc_inc_a: assert property (state_reg == ST_RUN && sw_cycle_i
        && cyc_evt && hicc_reg != HICC_MAX |=> hicc_reg == $past(hicc_reg)
        + 4'h1) else $error("hiccup count did not rise");
    hicc_dec_a: assert property (state_reg == ST_RUN && sw_cycle_i
        && !cyc_evt |=> hicc_reg == (($past(hicc_reg) == HICC_MIN) ?
        HICC_MIN : $past(hicc_reg) - 4'h1))
        else $error("hiccup count did not fall");
    hicc_hold_a: assert property (state_reg == ST_RUN && !sw_cycle_i
        && hicc_reg != HICC_MAX |=> $stable(hicc_reg))
        else $error("hiccup count moved off cycle");
    hicc_trip_a: assert property (s_full |=> stage_off_o
        ##1 (!hs_gate_o && !ls_gate_o))
        else $error("stage not off at full count");
    hicc_retry_a: assert property (s_expire |=> ss_restart_o
        && hicc_reg == HICC_MIN && !stage_off_o)
        else $error("no retry after inhibit");
    ls_block_a: assert property (ls_s |=> !hs_gate_o)
        else $error("high side on over low-side limit");
    blank_mask_a: assert property ($rose(hs_req_i) && !trunc_reg
        && !ls_s && run ##1 (hs_req_i && !ls_s && run) |=> hs_gate_o)
        else $error("high-side limit acted in blanking");
    trunc_a: assert property (hs_s && blank_reg == 4'h0 && !hs_rise
        |=> !hs_gate_o) else $error("high side not truncated");
    flag_clr_a: assert property (clr_reg && !hs_s && !ls_s && !tsd_s
        && !tw_s && !reg_req_i.wr |=> status[7:5] == 3'b000 && !clr_reg)
        else $error("flags not cleared");
    flag_keep_a: assert property (ocf_reg && !clr_reg |=> ocf_reg)
        else $error("overcurrent flag lost");
    stat_fix_a: assert property (status[ST_ONE] && !status[ST_ZERO]
        && status[ST_OK] == !(|status[7:5]))
        else $error("fixed status bits wrong");

endmodule
`default_nettype wire

// ===== verif/bfs_host.sv
// Register master model that stands in for the serial host controller
`timescale 1ns/1ns
`default_nettype none
module bfs_host
    import bfs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output bfs_reg_req_s    req_o,
    output logic            en_o
);
    // ------------------------------------------------------------------
    // Idle bus at time zero
    // ------------------------------------------------------------------
    initial begin
        req_o = '0;
        en_o  = 1'b0;
    end

    // One-cycle strobe; released lines show the inverse, not the old value
    task automatic xfer(input logic w, input logic [2:0] a,
                        input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    // Read data is registered at the taking edge, so sample just after it
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        #1 d = rdata_i;
    endtask

    task automatic set_en(input logic v);
        @(posedge clk_i);
        en_o <= v;
    endtask

    // Settings change only with delivery stopped, then resume
    task automatic cfg_write(input logic [2:0] a, input logic [7:0] d);
        set_en(1'b0);
        wr_reg(a, d);
        set_en(1'b1);
    endtask
endmodule
`default_nettype wire

// ===== verif/test_bfs_regs.sv
// Self-checking bench for the fault, hiccup and register logic
`timescale 1ns/1ns
`default_nettype none
module test_bfs_regs;
    import bfs_pkg::*;
    localparam int unsigned INH [4] = '{200, 400, 600, 800};
    logic clk = 0, nrst = 0, pg = 0, tw = 0, tsd = 0, ls = 0, hs = 0;
    logic sw = 0, hsr = 0, lsr = 0, en, hs_gate, ls_gate, stage_off;
    logic ss_rst, ldo_en;
    logic [7:0] rdata;
    bfs_reg_req_s req;
    bfs_cfg_s cfg;
    int n_mismatch = 0, samples_checked = 0;

    always #5 clk = ~clk;

    bfs_regs #(.INH_NS0(INH[0]), .INH_NS1(INH[1]), .INH_NS2(INH[2]),
        .INH_NS3(INH[3]), .CFG1_RST(8'hA8), .CFG2_RST(8'h7F),
        .LVL_RST(8'h5A)) u_bfs_regs (.clk_i(clk), .nrst_i(nrst),
        .reg_req_i(req), .reg_rdata_o(rdata), .en_pin_i(en),
        .pg_pin_i(pg), .therm_warn_i(tw), .therm_sd_i(tsd),
        .ls_limit_i(ls), .hs_limit_i(hs), .sw_cycle_i(sw),
        .hs_req_i(hsr), .ls_req_i(lsr), .hs_gate_o(hs_gate),
        .ls_gate_o(ls_gate), .stage_off_o(stage_off),
        .ss_restart_o(ss_rst), .ldo_enable_o(ldo_en), .cfg_o(cfg));
    bfs_host u_bfs_host (.clk_i(clk), .rdata_i(rdata), .req_o(req),
        .en_o(en));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check8(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic check1(string nm, logic e, logic g);
        check8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(logic [2:0] a, logic [7:0] e);
        logic [7:0] d;
        u_bfs_host.rd_reg(a, d);
        check8($sformatf("reg%0d", a), e, d);
    endtask
    task automatic sw_pulse;
        @(posedge clk) sw <= 1'b1;
        @(posedge clk) sw <= 1'b0;
    endtask
    task automatic clear_flags;
        u_bfs_host.wr_reg(ADDR_CMD, 8'h01);
        tick(1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_chk(ADDR_STAT, 8'h06);
        rd_chk(ADDR_CFG1, 8'hA8);
        rd_chk(ADDR_CFG2, 8'h73);
        rd_chk(ADDR_LEVEL, 8'h5A);
        rd_chk(ADDR_CMD, 8'h00);
        rd_chk(3'h5, 8'h00);
        check1("ldo", 1'b1, ldo_en);
        check8("current_limit_sel", 8'h02, {6'h00, cfg.current_limit_sel});
        check8("lvl_out", 8'h5A, cfg.output_level_value);
        check8("ss_mrg", 8'h03, {4'h0, cfg.margin_sel, cfg.soft_start_sel});
        check8("frq_dly", 8'h2F, {2'b00, cfg.freq_sel, cfg.startup_delay_sel});
    endtask
    task automatic t_live;
        u_bfs_host.set_en(1'b1);
        @(posedge clk) pg <= 1'b1;
        tick(4);
        rd_chk(ADDR_STAT, 8'h0F);
        @(posedge clk) pg <= 1'b0;
        tick(4);
        rd_chk(ADDR_STAT, 8'h0E);
    endtask
    task automatic t_therm;
        @(posedge clk) tw <= 1'b1;
        @(posedge clk) tw <= 1'b0;
        tick(4);
        rd_chk(ADDR_STAT, 8'h2C);
        clear_flags();
        rd_chk(ADDR_CMD, 8'h00);
        rd_chk(ADDR_STAT, 8'h0E);
        @(posedge clk) begin
            tsd <= 1'b1;
            hsr <= 1'b1;
        end
        tick(5);
        check1("hs_gate_tsd", 1'b0, hs_gate);
        check1("ldo_tsd", 1'b1, ldo_en);
        rd_chk(ADDR_STAT, 8'h4C);
        @(posedge clk) begin
            tsd <= 1'b0;
            hsr <= 1'b0;
        end
        clear_flags();
        rd_chk(ADDR_STAT, 8'h0E);
    endtask
    task automatic t_cfg;
        for (int i = 0; i < 4; i++) begin
            u_bfs_host.cfg_write(ADDR_CFG1, {i[1:0], 6'h3F});
            rd_chk(ADDR_CFG1, {i[1:0], 6'h38});
            check8("current_limit_sel", 8'(i), {6'h00, cfg.current_limit_sel});
        end
        u_bfs_host.cfg_write(ADDR_CFG2, 8'hFF);
        rd_chk(ADDR_CFG2, 8'h7F);
        u_bfs_host.wr_reg(ADDR_LEVEL, 8'hC3);
        rd_chk(ADDR_LEVEL, 8'hC3);
        check8("lvl_wr", 8'hC3, cfg.output_level_value);
        u_bfs_host.wr_reg(ADDR_CMD, 8'hFE);
        rd_chk(ADDR_CMD, 8'hFE);
        u_bfs_host.wr_reg(ADDR_STAT, 8'hF1);
        u_bfs_host.wr_reg(3'h6, 8'hFF);
        rd_chk(ADDR_STAT, 8'h0E);
        rd_chk(3'h6, 8'h00);
        @(posedge clk) nrst <= 1'b0;
        @(posedge clk) nrst <= 1'b1;
        rd_chk(ADDR_CFG1, 8'hA8);
        rd_chk(ADDR_CFG2, 8'h73);
        rd_chk(ADDR_LEVEL, 8'h5A);
        rd_chk(ADDR_CMD, 8'h00);
    endtask
    task automatic t_gate;
        @(posedge clk) hsr <= 1'b1;
        tick(4);
        check1("hs_gate_on", 1'b1, hs_gate);
        @(posedge clk) hsr <= 1'b0;
        @(posedge clk) ls <= 1'b1;
        tick(3);
        @(posedge clk) hsr <= 1'b1;
        tick(6);
        check1("hs_gate_blocked", 1'b0, hs_gate);
        @(posedge clk) ls <= 1'b0;
        tick(5);
        check1("hs_gate_back", 1'b1, hs_gate);
        @(posedge clk) hsr <= 1'b0;
        @(posedge clk) hs <= 1'b1;
        tick(3);
        @(posedge clk) hsr <= 1'b1;
        tick(9);
        check1("hs_gate_blank", 1'b1, hs_gate);
        tick(7);
        check1("hs_gate_trunc", 1'b0, hs_gate);
        @(posedge clk) hsr <= 1'b0;
        repeat (20) sw_pulse();
        tick(2);
        check1("stage_off_hs", 1'b0, stage_off);
        @(posedge clk) hs <= 1'b0;
        rd_chk(ADDR_STAT, 8'h8C);
        clear_flags();
        @(posedge clk) lsr <= 1'b1;
        tick(4);
        check1("ls_gate_on", 1'b1, ls_gate);
        @(posedge clk) lsr <= 1'b0;
    endtask
    // Counts inhibit cycles until the soft-start restart pulse
    task automatic wait_restart(output int n);
        n = 0;
        while (ss_rst !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n += int'(stage_off === 1'b1);
        end
    endtask
    task automatic t_hiccup(int s);
        int n, e;
        u_bfs_host.cfg_write(ADDR_CFG2, 8'h70 | 8'(s));
        e = INH[s] / 10 + 1;
        @(posedge clk) ls <= 1'b1;
        tick(3);
        repeat (14) sw_pulse();
        tick(2);
        check1("stage_off_14", 1'b0, stage_off);
        sw_pulse();
        tick(2);
        check1("stage_off_15", 1'b1, stage_off);
        check1("gates_off", 1'b0, hs_gate | ls_gate);
        wait_restart(n);
        n += 2;
        check1("inhibit_len", 1'b1, n >= e - 2 && n <= e + 2);
        tick(1);
        check1("restart_pulse", 1'b0, ss_rst);
        repeat (14) sw_pulse();
        tick(2);
        check1("rearm_14", 1'b0, stage_off);
        sw_pulse();
        tick(2);
        check1("rearm_15", 1'b1, stage_off);
        @(posedge clk) ls <= 1'b0;
        wait_restart(n);
        check1("restart_again", 1'b1, ss_rst);
        tick(2);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        tick(8);
        @(posedge clk) nrst <= 1'b1;
        t_reset();
        t_live();
        t_therm();
        t_cfg();
        t_gate();
        for (int s = 0; s < 4; s++) begin
            t_hiccup(s);
        end
        test_done();
    end
    initial begin
        #500_000;
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
